/* File: dram_refresh_requester.sv */
// Refresh requester and bus arbitration for a DRAM refresh unit.
// Assumes the bus_interface_unit side supplies cpu requests, bus ready and hold.
`timescale 1ns/1ps
module dram_refresh_requester
    import refresh_pkg::*;
#(
    parameter int INTERVAL_W = INTERVAL_WIDTH
)
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Refresh unit configuration
    input  wire logic                    refreshEnable,
    input  wire logic [INTERVAL_W-1:0]   refreshIntervalReload,
    input  wire logic [BASE_WIDTH-1:0]   refreshBase,
    // Cpu request
    input  wire logic                    cpuReq,
    input  wire logic [ADDR_WIDTH-1:0]   cpuAddr,
    output logic                         cpuGrant,
    // Bus cycle
    input  wire logic                    busReady,
    output logic                         busCycle,
    output logic [ADDR_WIDTH-1:0]        busAddr,
    output logic [2:0]                   busStatus,
    output logic                         chipSelect,
    output logic                         refreshCycle,
    // External hold
    input  wire logic                    holdReq,
    output logic                         holdAck,
    // Observation
    output logic                         refreshPending,
    output logic [INTERVAL_W-1:0]        intervalCount
);
    // ====================================================
    // Input synchronisation for the hold pin
    logic [2:0] holdSync_r;
    logic       holdLevel_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            holdSync_r  <= 3'h0;
            holdLevel_r <= 1'b0;
        end else begin
            holdSync_r <= {holdSync_r[1:0], holdReq};
            if (holdSync_r[1] == holdSync_r[2]) begin
                holdLevel_r <= holdSync_r[2];
            end
        end
    end

    // ====================================================
    // Interval counter
    logic [INTERVAL_W-1:0] count_r;
    logic                  enable_r;
    logic                  fire;

    assign fire = enable_r && (count_r == INTERVAL_W'(INTERVAL_FIRE));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_r <= 1'b0;
            count_r  <= INTERVAL_W'(INTERVAL_CLEAR);
        end else begin
            enable_r <= refreshEnable;
            if (!refreshEnable) begin
                count_r <= INTERVAL_W'(INTERVAL_CLEAR);
            end else if (!enable_r || fire) begin
                count_r <= refreshIntervalReload;
            end else begin
                count_r <= count_r - INTERVAL_W'(INTERVAL_FIRE);
            end
        end
    end

    // ====================================================
    // Bus arbitration
    bus_state_t            state_r;
    logic                  pending_r;
    logic                  serviced;
    logic [ROW_WIDTH-1:0]  rowAddr;
    logic [ADDR_WIDTH-1:0] refreshAddr;

    assign serviced = (state_r == BUS_REFRESH) && busReady;

    // Only one request is kept; a new one before service merges with it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending_r <= 1'b0;
        end else if (!refreshEnable) begin
            pending_r <= 1'b0;
        end else if (fire) begin
            pending_r <= 1'b1;
        end else if (serviced) begin
            pending_r <= 1'b0;
        end
    end

    assign refreshAddr = {refreshBase, rowAddr, ADDR_FIXED_BIT};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r      <= BUS_IDLE;
            busAddr      <= '0;
            busStatus    <= STATUS_IDLE;
            chipSelect   <= 1'b0;
            busCycle     <= 1'b0;
            refreshCycle <= 1'b0;
            holdAck      <= 1'b0;
        end else begin
            case (state_r)
                BUS_IDLE: begin
                    if (pending_r) begin
                        // Refresh first, ahead of cpu and hold
                        state_r      <= BUS_REFRESH;
                        busAddr      <= refreshAddr;
                        busStatus    <= STATUS_READ;
                        chipSelect   <= 1'b1;
                        busCycle     <= 1'b1;
                        refreshCycle <= 1'b1;
                    end else if (holdLevel_r) begin
                        state_r <= BUS_HOLD;
                        holdAck <= 1'b1;
                    end else if (cpuReq) begin
                        state_r    <= BUS_CPU;
                        busAddr    <= cpuAddr;
                        busStatus  <= STATUS_READ;
                        chipSelect <= 1'b1;
                        busCycle   <= 1'b1;
                    end
                end
                BUS_CPU, BUS_REFRESH: begin
                    // Wait states stretch the cycle until ready
                    if (busReady) begin
                        state_r      <= BUS_IDLE;
                        busStatus    <= STATUS_IDLE;
                        chipSelect   <= 1'b0;
                        busCycle     <= 1'b0;
                        refreshCycle <= 1'b0;
                    end
                end
                BUS_HOLD: begin
                    if (pending_r) begin
                        holdAck <= 1'b0;
                    end
                    if (!holdLevel_r) begin
                        // Bus returns only once hold is removed
                        state_r <= BUS_IDLE;
                        holdAck <= 1'b0;
                    end
                end
                default: begin
                    state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    assign cpuGrant = (state_r == BUS_IDLE) && !pending_r && !holdLevel_r && cpuReq;

    row_counter u_row (
        .ref_clk (ref_clk),
        .rst     (rst),
        .advance (serviced),
        .rowAddr (rowAddr)
    );

    assign refreshPending = pending_r;
    assign intervalCount  = count_r;
endmodule : dram_refresh_requester

/* File: refresh_pkg.sv */
// Shared constants for the refresh requester.
// Assumes one 100 MHz clock and no software-visible registers.
package refresh_pkg;
    localparam int INTERVAL_WIDTH = 9;
    localparam int ROW_WIDTH      = 12;
    localparam int BASE_WIDTH     = 7;
    localparam int ADDR_WIDTH     = 20;
    localparam logic [INTERVAL_WIDTH-1:0] INTERVAL_FIRE  = 9'h001;
    localparam logic [INTERVAL_WIDTH-1:0] INTERVAL_CLEAR = 9'h000;
    localparam logic [ROW_WIDTH-1:0]      ROW_RESET      = 12'h000;
    localparam logic                      ADDR_FIXED_BIT = 1'b1;
    localparam logic [ROW_WIDTH-1:0]      ROW_TAPS       = 12'h0829;
    localparam logic [2:0] STATUS_READ = 3'h5;
    localparam logic [2:0] STATUS_IDLE = 3'h7;
    typedef enum logic [1:0] {BUS_IDLE, BUS_CPU, BUS_REFRESH, BUS_HOLD} bus_state_t;
endpackage : refresh_pkg

/* File: row_counter.sv */
// Refresh row address counter, a 12-bit linear-feedback shift counter.
// Assumes the caller pulses advance once per completed refresh cycle.
`timescale 1ns/1ps
module row_counter
    import refresh_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Control
    input  wire logic                 advance,
    // Row value
    output logic [ROW_WIDTH-1:0]      rowAddr
);
    logic [ROW_WIDTH-1:0] row_r;

    // Advance only on service, so requests may be lost but never rows
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            row_r <= ROW_RESET;
        end else if (advance) begin
            row_r <= {row_r[ROW_WIDTH-2:0], ~^(row_r & ROW_TAPS)};
        end
    end

    assign rowAddr = row_r;
endmodule : row_counter

/* File: refresh_assertions.sv */
// Port-level checks for the refresh requester.
// Assumes a bind onto dram_refresh_requester; one clock domain.
`timescale 1ns/1ps
module refresh_assertions
    import refresh_pkg::*;
#(parameter int INTERVAL_W = INTERVAL_WIDTH)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Watched ports
    input wire logic refreshEnable, busReady, cpuGrant, busCycle,
    input wire logic chipSelect, refreshCycle, holdAck, refreshPending,
    input wire logic [INTERVAL_W-1:0] refreshIntervalReload, intervalCount,
    input wire logic [BASE_WIDTH-1:0] refreshBase,
    input wire logic [ADDR_WIDTH-1:0] busAddr,
    input wire logic [2:0] busStatus
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_fire; refreshEnable && intervalCount == INTERVAL_FIRE; endsequence
    sequence s_served; refreshCycle && busReady; endsequence
    a_fire_reload: assert property (s_fire |=> refreshPending
        && intervalCount == $past(refreshIntervalReload)) else $error("no reload");
    a_count_down: assert property (refreshEnable && intervalCount > INTERVAL_FIRE
        |=> intervalCount == $past(intervalCount) - 1) else $error("no decrement");
    a_disable_clear: assert property (!refreshEnable
        |=> intervalCount == INTERVAL_CLEAR && !refreshPending) else $error("not cleared");
    a_pend_hold: assert property (refreshPending && refreshEnable
        && !(refreshCycle && busReady) |=> refreshPending) else $error("request lost");
    // A new fire on the serving edge re-arms the request, so it is excluded
    a_service_clr: assert property (s_served ##0 !(refreshEnable
        && intervalCount == INTERVAL_FIRE)
        |=> !refreshPending && !refreshCycle) else $error("request kept");
    a_refresh_read: assert property (refreshCycle |-> busCycle && chipSelect
        && busStatus == STATUS_READ && busAddr[ADDR_WIDTH-1:13] == refreshBase
        && busAddr[0] == ADDR_FIXED_BIT) else $error("bad refresh read");
    a_refresh_wins: assert property (refreshPending |-> !cpuGrant) else $error("cpu won");
    a_hold_yield: assert property (refreshPending && holdAck |=> !holdAck)
        else $error("hold kept");
endmodule : refresh_assertions

/* File: dram_partner.sv */
// Far-side model: answers bus cycles with ready, at once or after one wait.
// Assumes busCycle is registered in the requester.
`timescale 1ns/1ps
module dram_partner (
    input wire logic ref_clk,
    input wire logic busCycle,
    input wire logic slowMode,
    output logic     busReady,
    output logic     rowStrobe
);
    logic [1:0] waitCnt = 2'h0;
    initial busReady = 1'b0;
    // Idle ready toggles so a stray sample never sees a steady level
    always @(posedge ref_clk) begin
        #1;
        if (!busCycle) waitCnt = slowMode ? 2'h2 : 2'h0;
        else if (waitCnt != 2'h0) waitCnt = waitCnt - 2'h1;
        busReady = busCycle ? waitCnt == 2'h0 : !busReady;
    end
    assign rowStrobe = busCycle && !busReady;
endmodule : dram_partner

/* File: test_dram_refresh_requester.sv */
// Self-checking bench for the refresh requester.
// Assumes dram_partner answers the bus; cpuAddr is tied.
`timescale 1ns/1ps
module test_dram_refresh_requester;
    import refresh_pkg::*;
    typedef struct {logic [8:0] reload; logic [6:0] base;} case_t;
    case_t rows [3] = '{'{9'h012, 7'h00}, '{9'h021, 7'h7F}, '{9'h1FF, 7'h55}};
    logic ref_clk = 1'b0, rst = 1'b1, refreshEnable = 1'b0, cpuReq = 1'b0;
    logic holdReq = 1'b0, slowMode = 1'b0, busReady, cpuGrant, busCycle, chipSelect;
    logic refreshCycle, holdAck, refreshPending;
    logic [8:0] refreshIntervalReload = 9'h012, intervalCount;
    logic [6:0] refreshBase = 7'h00;
    logic [19:0] busAddr, lastAddr;
    logic [2:0] busStatus;
    int mismatches = 0, checks = 0, n;
    dram_refresh_requester #(.INTERVAL_W(9)) i_dram_refresh_requester (.*, .cpuAddr(20'h0_1230));
    dram_partner i_dram_partner (.ref_clk(ref_clk), .busCycle(busCycle), .slowMode(slowMode),
        .busReady(busReady), .rowStrobe());
    initial forever #5 ref_clk = !ref_clk;
    task automatic check(input logic [19:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    // Bounded wait; a hang ends the run as a failure
    task automatic waitFor(ref logic sig, input logic val);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (sig !== val && n < 700);
        if (n >= 700) begin
            mismatches++;
            give_verdict();
        end
    endtask : waitFor
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        tick(12);
        rst = 1'b0;
        check({refreshPending, intervalCount}, 10'h000);
        check(busStatus, STATUS_IDLE);
        $display("test reset done");
        foreach (rows[i]) begin
            refreshIntervalReload = rows[i].reload;
            refreshBase = rows[i].base;
            refreshEnable = 1'b1;
            waitFor(refreshCycle, 1'b1);
            if (i == 0) check(busAddr[12:1], ROW_RESET);
            check(busAddr, {rows[i].base, busAddr[12:1], ADDR_FIXED_BIT});
            lastAddr = busAddr;
            waitFor(refreshCycle, 1'b1);
            check(n, rows[i].reload);
            check(busAddr[12:1] != lastAddr[12:1], 1'b1);
            refreshEnable = 1'b0;
            tick(1);
            check({refreshPending, intervalCount}, 10'h000);
            $display("test row %0d done", i);
        end
        slowMode = 1'b1;
        cpuReq = 1'b1;
        refreshIntervalReload = 9'h012;
        refreshEnable = 1'b1;
        tick(1);
        check({busCycle, refreshCycle}, 2'h2);
        check(busAddr, 20'h0_1230);
        check({chipSelect, busStatus}, {1'b1, STATUS_READ});
        waitFor(refreshPending, 1'b1);
        check(cpuGrant, 1'b0);
        waitFor(refreshCycle, 1'b1);
        check(busStatus, STATUS_READ);
        cpuReq = 1'b0;
        refreshEnable = 1'b0;
        slowMode = 1'b0;
        $display("test contention done");
        holdReq = 1'b1;
        waitFor(holdAck, 1'b1);
        refreshEnable = 1'b1;
        waitFor(refreshPending, 1'b1);
        tick(2);
        check({holdAck, busCycle}, 2'h0);
        holdReq = 1'b0;
        waitFor(refreshCycle, 1'b1);
        check(busAddr[0], ADDR_FIXED_BIT);
        $display("test hold done");
        give_verdict();
    end
endmodule : test_dram_refresh_requester
bind dram_refresh_requester refresh_assertions #(.INTERVAL_W(INTERVAL_W)) i_refresh_assertions (.*);
